// *** rtl/cp_memory_params.svh ***
// constants for the memory-access block
`ifndef CP_MEMORY_PARAMS_SVH
`define CP_MEMORY_PARAMS_SVH

// ====
// exchange package flag register bit positions
`define FLAG_EXT_ENABLE_BIT   56
`define FLAG_EXT_PURGE_BIT    52

// ====
// block copy field positions and block size
`define BC_FLAG_OP_BIT        23
`define BC_PARCEL_BIT_LO      21
`define BC_PARCEL_BIT_HI      22
`define BC_BLOCK_WORDS        7'h40
`define BC_CNT_W              18

// ====
// widths
`define WORD_W                60
`define ADDR_W                24
`define CM_REL_W              21

// ====
// opcodes as {fm, i}, 9 bits
`define OP_RETURN_JUMP        9'h008
`define OP_BC_READ            9'h009
`define OP_BC_WRITE           9'h00a
`define OP_EXCHANGE_JUMP      9'h00b
`define OP_EXT_READ           9'h00c
`define OP_EXT_WRITE          9'h00d
`define OP_CM_READ            9'h1b0
`define OP_CM_WRITE           9'h1b8
`define FM_BRANCH             6'h02
`define FM_COND_LO            6'h03
`define FM_COND_HI            6'h07
`define FM_STORE_LO           6'h28
`define FM_STORE_HI           6'h2f
`define I_STORE_LO            3'h6

`endif

// *** rtl/cp_memory_pkg.sv ***
// types shared by the memory-access instruction block
package cp_memory_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BC_RD,
    ST_BC_WR,
    ST_SINGLE
  } exec_state_e;
endpackage

// *** rtl/fetch_fifo.sv ***
// two-entry shifting prefetch buffer with flush
`timescale 1ns/1ps
`default_nettype none
module fetch_fifo #(
  parameter int W     = 60,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // fill side
  input  wire logic                       push,
  input  wire logic [W-1:0]               push_data,
  input  wire logic                       flush,
  // drain side
  input  wire logic                       pop,
  output logic                            out_valid,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
  } fifo_s;

  fifo_s r;
  fifo_s n;

  // ====
  // next state
  always_comb begin
    logic [CW-1:0] c;
    c = r.cnt;
    n = r;
    if (pop && c != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        n.mem[i] = r.mem[i+1];
      end
      c = c - CW'(1);
    end
    // a pushed word lands behind the survivors
    if (push && c != CW'(DEPTH)) begin
      n.mem[c] = push_data;
      c = c + CW'(1);
    end
    n.cnt = c;
    if (flush) begin
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[0];
  assign count     = r.cnt;
endmodule // fetch_fifo
`default_nettype wire

// *** rtl/cp_memory_instr_and_lookahead.sv ***
// memory-access instruction execution and instruction lookahead
//
// Functional notes
// - monitor flag set means monitor mode
// - extended ops need extended enable flag
// - exchange breakin allowed after each 64-word block
// - copy flag-register operation is illegal
// - offset-plus-base bit 21/22 selects parcel 2
// - negative index plus K gives range error
// - 014 reads, 015 writes extended word
// - 660 reads main word at 21-bit address
// - 670 writes main word at 21-bit address
// - nonzero i keeps legacy 66/67 behaviour
// - lookahead prefetches two words into FIFO
// - normal purge on 010, 011, 013, 02
// - extended purge adds conditional jumps and stores
// - extended purge refetches word after store
// - store then branch runs modified code
// - nonexistent address drops writes, reads ones
`timescale 1ns/1ps
`default_nettype none
`include "cp_memory_params.svh"
module cp_memory_instr_and_lookahead
  import cp_memory_pkg::*;
#(
  parameter int XW = `WORD_W,
  parameter int AW = `ADDR_W
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // issued instruction and operands
  input  wire logic                 instr_valid,
  input  wire logic [8:0]           instr_op,
  input  wire logic [2:0]           instr_j,
  input  wire logic [XW-1:0]        operand_reg_dest,
  input  wire logic [XW-1:0]        operand_reg_addr,
  input  wire logic [XW-1:0]        block_copy_offset_reg,
  input  wire logic [`BC_CNT_W-1:0] index_reg,
  input  wire logic [`BC_CNT_W-1:0] k_const,
  input  wire logic [AW-1:0]        copy_main_addr,
  // exchange package state
  input  wire logic [XW-1:0]        flag_reg,
  input  wire logic                 monitor_flag,
  input  wire logic [AW-1:0]        main_base_address,
  input  wire logic [AW-1:0]        extended_base_address,
  input  wire logic [AW-1:0]        extended_field_length,
  input  wire logic [AW-1:0]        main_installed_words,
  input  wire logic [AW-1:0]        ext_installed_words,
  input  wire logic                 exchange_req,
  // data memory port
  output logic                      mem_req,
  output logic                      mem_we,
  output logic                      mem_ext,
  output logic [AW-1:0]             mem_addr,
  output logic [XW-1:0]             mem_wdata,
  input  wire logic                 mem_ack,
  input  wire logic [XW-1:0]        mem_rdata,
  // instruction fetch port
  output logic                      if_req,
  output logic [AW-1:0]             if_addr,
  input  wire logic                 if_ack,
  input  wire logic [XW-1:0]        if_rdata,
  // redirect and lookahead drain
  input  wire logic                 redirect_valid,
  input  wire logic [AW-1:0]        redirect_addr,
  input  wire logic [AW-1:0]        seq_next_addr,
  input  wire logic                 ib_pop,
  output logic                      ib_valid,
  output logic [XW-1:0]             ib_data,
  // results and status
  output logic                      busy,
  output logic                      done,
  output logic                      wb_valid,
  output logic [2:0]                wb_reg,
  output logic [XW-1:0]             wb_data,
  output logic                      illegal_instr,
  output logic                      addr_range_err,
  output logic                      breakin_ok,
  output logic                      breakin_taken,
  output logic                      next_parcel2,
  output logic                      purge,
  output logic                      monitor_mode,
  output logic                      job_mode
);

  typedef struct packed {
    exec_state_e          st;
    logic                 phase;
    logic                 bc_from_ext;
    logic                 is_read;
    logic [AW-1:0]        src;
    logic [AW-1:0]        dst;
    logic [`BC_CNT_W-1:0] remain;
    logic [6:0]           blk;
    logic                 mem_req;
    logic                 mem_we;
    logic                 mem_ext;
    logic [AW-1:0]        mem_addr;
    logic [XW-1:0]        mem_wdata;
    logic                 wb_valid;
    logic [2:0]           wb_reg;
    logic [XW-1:0]        wb_data;
    logic                 done;
    logic                 illegal;
    logic                 range_err;
    logic                 breakin_ok;
    logic                 breakin_taken;
    logic                 parcel2;
    logic                 purge;
    logic                 monitor_mode;
    logic                 job_mode;
    logic                 if_req;
    logic                 if_drop;
    logic [AW-1:0]        if_addr;
  } exec_s;

  exec_s r;
  exec_s n;

  logic       fifo_push;
  logic [1:0] fifo_cnt;

  // ====
  // decode helpers
  function automatic logic normal_purge_op(input logic [8:0] op);
    return op == `OP_RETURN_JUMP || op == `OP_BC_READ ||
           op == `OP_EXCHANGE_JUMP || op[8:3] == `FM_BRANCH;
  endfunction

  function automatic logic extended_purge_op(input logic [8:0] op);
    logic cond;
    logic store;
    cond  = op[8:3] >= `FM_COND_LO && op[8:3] <= `FM_COND_HI;
    store = op[8:3] >= `FM_STORE_LO && op[8:3] <= `FM_STORE_HI && op[2:0] >= `I_STORE_LO;
    return cond || store;
  endfunction

  function automatic logic is_ext_op(input logic [8:0] op);
    return op == `OP_BC_READ || op == `OP_BC_WRITE ||
           op == `OP_EXT_READ || op == `OP_EXT_WRITE;
  endfunction

  function automatic logic nonexistent(input logic [AW-1:0] a, input logic ext);
    return ext ? (a >= ext_installed_words) : (a >= main_installed_words);
  endfunction

  // ====
  // next state
  always_comb begin
    logic                 ext_en;
    logic                 xpurge;
    logic [`BC_CNT_W-1:0] cnt;
    logic [AW-1:0]        xe;
    logic                 acc_done;
    logic [XW-1:0]        acc_data;
    n = r;
    n.wb_valid      = 1'b0;
    n.done          = 1'b0;
    n.illegal       = 1'b0;
    n.range_err     = 1'b0;
    n.breakin_ok    = 1'b0;
    n.breakin_taken = 1'b0;
    n.purge         = 1'b0;
    ext_en   = flag_reg[`FLAG_EXT_ENABLE_BIT];
    // software owns bit 52; hardware only follows it
    // extended purge select
    xpurge   = flag_reg[`FLAG_EXT_PURGE_BIT];
    cnt      = index_reg + k_const;
    xe       = block_copy_offset_reg[AW-1:0] + extended_base_address;
    acc_done = 1'b0;
    acc_data = mem_rdata;

    n.monitor_mode = monitor_flag;
    n.job_mode     = !monitor_flag;

    // ====
    // shared single-word access: phase 0 decides, phase 1 waits for ack
    if (r.st != ST_IDLE) begin
      if (!r.phase) begin
        if (nonexistent(r.mem_addr, r.mem_ext)) begin
          acc_done = 1'b1;
          acc_data = '1;
        end else begin
          n.mem_req = 1'b1;
          n.phase   = 1'b1;
        end
      end else if (mem_ack) begin
        n.mem_req = 1'b0;
        n.phase   = 1'b0;
        acc_done  = 1'b1;
      end
    end

    unique case (r.st)
      ST_IDLE: begin
        if (instr_valid) begin
          n.purge = normal_purge_op(instr_op) || (xpurge && extended_purge_op(instr_op));
          if (is_ext_op(instr_op) && !ext_en) begin
            n.illegal = 1'b1;
            n.done    = 1'b1;
          end else if (instr_op == `OP_BC_READ || instr_op == `OP_BC_WRITE) begin
            n.parcel2 = xe[`BC_PARCEL_BIT_LO] | xe[`BC_PARCEL_BIT_HI];
            if (block_copy_offset_reg[`BC_FLAG_OP_BIT] &&
                extended_field_length[`BC_FLAG_OP_BIT]) begin
              n.illegal = 1'b1;
              n.done    = 1'b1;
            // negative count is a range error
            end else if (cnt[`BC_CNT_W-1]) begin
              n.range_err = 1'b1;
              n.done      = 1'b1;
            end else if (cnt == '0) begin
              n.done = 1'b1;
            end else begin
              n.bc_from_ext = (instr_op == `OP_BC_READ);
              n.src      = (instr_op == `OP_BC_READ) ? xe : copy_main_addr + main_base_address;
              n.dst      = (instr_op == `OP_BC_READ) ? copy_main_addr + main_base_address : xe;
              n.remain   = cnt;
              n.blk      = '0;
              n.mem_we   = 1'b0;
              n.mem_ext  = n.bc_from_ext;
              n.mem_addr = n.src;
              n.st       = ST_BC_RD;
            end
          end else if (instr_op == `OP_EXT_READ || instr_op == `OP_EXT_WRITE) begin
            // single extended word at offset plus base
            n.is_read   = (instr_op == `OP_EXT_READ);
            n.mem_we    = (instr_op == `OP_EXT_WRITE);
            n.mem_ext   = 1'b1;
            n.mem_addr  = operand_reg_addr[AW-1:0] + extended_base_address;
            n.mem_wdata = operand_reg_dest;
            n.wb_reg    = instr_j;
            n.st        = ST_SINGLE;
          // exact match leaves nonzero i to legacy logic
          end else if (instr_op == `OP_CM_READ || instr_op == `OP_CM_WRITE) begin
            // read uses low 21 bits only
            // write uses low 21 bits only
            n.is_read   = (instr_op == `OP_CM_READ);
            n.mem_we    = (instr_op == `OP_CM_WRITE);
            n.mem_ext   = 1'b0;
            n.mem_addr  = AW'(operand_reg_addr[`CM_REL_W-1:0]) + main_base_address;
            n.mem_wdata = operand_reg_dest;
            n.wb_reg    = instr_j;
            n.st        = ST_SINGLE;
          end
        end
      end
      ST_SINGLE: begin
        if (acc_done) begin
          n.wb_valid = r.is_read;
          n.wb_data  = acc_data;
          n.done     = 1'b1;
          n.st       = ST_IDLE;
        end
      end
      ST_BC_RD: begin
        if (acc_done) begin
          n.mem_wdata = acc_data;
          n.mem_we    = 1'b1;
          n.mem_ext   = !r.bc_from_ext;
          n.mem_addr  = r.dst;
          n.st        = ST_BC_WR;
        end
      end
      ST_BC_WR: begin
        if (acc_done) begin
          n.remain   = r.remain - `BC_CNT_W'(1);
          n.blk      = r.blk + 7'h01;
          n.src      = r.src + AW'(1);
          n.dst      = r.dst + AW'(1);
          n.mem_we   = 1'b0;
          n.mem_ext  = r.bc_from_ext;
          n.mem_addr = r.src + AW'(1);
          n.st       = ST_BC_RD;
          if (r.remain == `BC_CNT_W'(1)) begin
            n.done = 1'b1;
            n.st   = ST_IDLE;
          end else if (r.blk + 7'h01 == `BC_BLOCK_WORDS) begin
            n.blk        = '0;
            n.breakin_ok = 1'b1;
            if (exchange_req) begin
              n.breakin_taken = 1'b1;
              n.done          = 1'b1;
              n.st            = ST_IDLE;
            end
          end
        end
      end
    endcase

    // ====
    // lookahead fetch: one fetch in flight, buffer holds two words
    // an abandoned fetch still answers once; its ack only clears the drop
    if ((r.if_req || r.if_drop) && if_ack) begin
      n.if_req  = 1'b0;
      n.if_drop = 1'b0;
      if (!r.if_drop) begin
        n.if_addr = r.if_addr + AW'(1);
      end
    end
    if (!r.if_req && fifo_cnt < 2'h2) begin
      n.if_req = 1'b1;
    end
    // purge refetches the word after the store
    if (redirect_valid) begin
      n.if_addr = redirect_addr;
      n.if_drop = r.if_req && !if_ack;
      n.if_req  = 1'b0;
    end else if (n.purge) begin
      n.if_addr = seq_next_addr;
      n.if_drop = r.if_req && !if_ack;
      n.if_req  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ====
  // prefetch buffer; a word fetched before a purge is dropped
  assign fifo_push = r.if_req && if_ack && !r.if_drop && !redirect_valid && !n.purge;

  fetch_fifo #(
    .W     (XW),
    .DEPTH (2)
  ) u_lookahead (
    .clk       (clk),
    .srst      (srst),
    .push      (fifo_push),
    .push_data (if_rdata),
    .flush     (redirect_valid || n.purge),
    .pop       (ib_pop),
    .out_valid (ib_valid),
    .out_data  (ib_data),
    .count     (fifo_cnt)
  );

  assign busy           = (r.st != ST_IDLE);
  assign done           = r.done;
  assign wb_valid       = r.wb_valid;
  assign wb_reg         = r.wb_reg;
  assign wb_data        = r.wb_data;
  assign illegal_instr  = r.illegal;
  assign addr_range_err = r.range_err;
  assign breakin_ok     = r.breakin_ok;
  assign breakin_taken  = r.breakin_taken;
  assign next_parcel2   = r.parcel2;
  assign purge          = r.purge;
  assign monitor_mode   = r.monitor_mode;
  assign job_mode       = r.job_mode;
  assign mem_req        = r.mem_req;
  assign mem_we         = r.mem_we;
  assign mem_ext        = r.mem_ext;
  assign mem_addr       = r.mem_addr;
  assign mem_wdata      = r.mem_wdata;
  assign if_req         = r.if_req;
  assign if_addr        = r.if_addr;
endmodule // cp_memory_instr_and_lookahead
`default_nettype wire

// *** tb/cp_memory_monitor.sv ***
// assertion checker for the memory-access block
`timescale 1ns/1ps
`default_nettype none
`include "cp_memory_params.svh"
module cp_memory_monitor #(
  parameter int XW = 60,
  parameter int AW = 24
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          srst,
  // issue side
  input wire logic          instr_valid,
  input wire logic [8:0]    instr_op,
  input wire logic [XW-1:0] operand_reg_addr,
  input wire logic [XW-1:0] block_copy_offset_reg,
  input wire logic [17:0]   index_reg,
  input wire logic [17:0]   k_const,
  input wire logic [XW-1:0] flag_reg,
  input wire logic          monitor_flag,
  input wire logic [AW-1:0] main_base_address,
  input wire logic [AW-1:0] extended_base_address,
  input wire logic [AW-1:0] extended_field_length,
  input wire logic [AW-1:0] main_installed_words,
  // memory port
  input wire logic          mem_req,
  input wire logic          mem_we,
  input wire logic          mem_ext,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [XW-1:0] mem_wdata,
  input wire logic          mem_ack,
  // results
  input wire logic          busy,
  input wire logic          done,
  input wire logic          wb_valid,
  input wire logic [XW-1:0] wb_data,
  input wire logic          illegal_instr,
  input wire logic          addr_range_err,
  input wire logic          breakin_taken,
  input wire logic          next_parcel2,
  input wire logic          purge,
  input wire logic          monitor_mode,
  input wire logic          job_mode
);
  // ====
  // decode helpers
  wire logic          take   = instr_valid && !busy;
  wire logic [5:0]    fm     = instr_op[8:3];
  wire logic          en     = flag_reg[`FLAG_EXT_ENABLE_BIT];
  wire logic          bc     = take && (instr_op == `OP_BC_READ || instr_op == `OP_BC_WRITE);
  wire logic          sw     = take && (instr_op == `OP_EXT_READ || instr_op == `OP_EXT_WRITE);
  wire logic          cm     = take && (instr_op == `OP_CM_READ || instr_op == `OP_CM_WRITE);
  wire logic          fop    = block_copy_offset_reg[23] && extended_field_length[23];
  wire logic [17:0]   wc     = index_reg + k_const;
  wire logic [AW-1:0] cm_abs = AW'(operand_reg_addr[20:0]) + main_base_address;
  wire logic          cm_in  = cm_abs < main_installed_words;
  wire logic [AW-1:0] ex_abs = operand_reg_addr[AW-1:0] + extended_base_address;
  wire logic [AW-1:0] sel    = block_copy_offset_reg[AW-1:0] + extended_base_address;
  wire logic          p2     = sel[21] || sel[22];
  wire logic          pn     = take && (instr_op == `OP_RETURN_JUMP || instr_op == `OP_BC_READ
                               || instr_op == `OP_EXCHANGE_JUMP || fm == `FM_BRANCH);
  wire logic          pe     = take && flag_reg[`FLAG_EXT_PURGE_BIT]
                               && ((fm >= `FM_COND_LO && fm <= `FM_COND_HI)
                               || (fm >= `FM_STORE_LO && fm <= `FM_STORE_HI
                               && instr_op[2:0] >= `I_STORE_LO));
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ====
  // properties
  a_mode_follow: assert property (!$past(srst) |-> monitor_mode == $past(monitor_flag)
    && job_mode == !$past(monitor_flag)) else $error("mode wrong");
  a_ext_refused: assert property ((bc || sw) && !en |=> illegal_instr && done && !mem_req)
    else $error("not refused");
  a_copy_flagop: assert property (bc && en && fop |=> illegal_instr && done)
    else $error("flag op legal");
  a_neg_count: assert property (bc && en && !fop && wc[17] |=> addr_range_err && done)
    else $error("no range error");
  a_parcel_sel: assert property (bc && en && !fop && !wc[17] |=> next_parcel2 == $past(p2))
    else $error("parcel wrong");
  a_main_addr: assert property (cm && cm_in |=> mem_addr == $past(cm_abs) && !mem_ext
    && mem_we == $past(instr_op[3])) else $error("main addr wrong");
  a_ext_addr: assert property (sw && en |=> mem_addr == $past(ex_abs) && mem_ext
    && mem_we == $past(instr_op[0])) else $error("ext addr wrong");
  a_nonexist_rd: assert property (cm && !cm_in && !instr_op[3] |=> !mem_req ##1
    wb_valid && done && wb_data == '1) else $error("not all ones");
  a_legacy_iop: assert property (take && (fm == 6'h36 || fm == 6'h37) && instr_op[2:0] != 3'h0
    |=> !busy && !mem_req) else $error("legacy access");
  a_purge_set: assert property (pn || pe |=> purge) else $error("purge missing");
  a_purge_none: assert property (!(pn || pe) |=> !purge) else $error("spurious purge");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("request changed");
  a_breakin_end: assert property (breakin_taken |-> done) else $error("no done");
  c_purge: cover property (purge);
  c_breakin: cover property (breakin_taken);
  c_writeback: cover property (wb_valid && !mem_req);
endmodule // cp_memory_monitor

bind cp_memory_instr_and_lookahead cp_memory_monitor #(.XW(XW), .AW(AW)) u_mon (.*);
`default_nettype wire

// *** tb/mem_model.sv ***
// main and extended store plus instruction fetch responder
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // clock, reset and pacing
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        slow,
  // data port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_ext,
  input  wire logic [23:0] mem_addr,
  input  wire logic [59:0] mem_wdata,
  output logic             mem_ack,
  output logic [59:0]      mem_rdata,
  // fetch port
  input  wire logic        if_req,
  input  wire logic [23:0] if_addr,
  output logic             if_ack,
  output logic [59:0]      if_rdata
);
  logic [59:0] mm [256];
  logic [59:0] em [256];
  logic [1:0]  wait_r;
  always_ff @(posedge clk) begin
    mem_ack <= 1'b0;
    if_ack <= 1'b0;
    // outside an answer the lines toggle, so a stale value never matches
    mem_rdata <= ~mem_rdata;
    if_rdata <= ~if_rdata;
    if (srst) begin
      mem_rdata <= '0;
      if_rdata <= '0;
      wait_r <= 2'h0;
    end else begin
      if (mem_req && !mem_ack) begin
        if (wait_r != 2'h0) begin
          wait_r <= wait_r - 2'h1;
        end else begin
          mem_ack <= 1'b1;
          mem_rdata <= mem_ext ? em[mem_addr[7:0]] : mm[mem_addr[7:0]];
          if (mem_we && mem_ext) em[mem_addr[7:0]] <= mem_wdata;
          if (mem_we && !mem_ext) mm[mem_addr[7:0]] <= mem_wdata;
        end
      end else begin
        wait_r <= slow ? 2'h3 : 2'h0;
      end
      if (if_req && !if_ack) begin
        if_ack <= 1'b1;
        if_rdata <= {36'h0, if_addr} ^ 60'h0a5a_5a5a;
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the memory-access block
`timescale 1ns/1ps
`default_nettype none
`include "cp_memory_params.svh"
module tb;
  logic        clk, srst, instr_valid, monitor_flag, exchange_req, redirect_valid, ib_pop, slow;
  logic        mem_req, mem_we, mem_ext, mem_ack, if_req, if_ack, ib_valid, busy, done, wb_valid;
  logic        illegal_instr, addr_range_err, breakin_ok, breakin_taken, next_parcel2, purge;
  logic        monitor_mode, job_mode;
  logic [8:0]  instr_op;
  logic [2:0]  instr_j, wb_reg, wbr;
  logic [6:0]  s;
  logic [17:0] index_reg, k_const;
  logic [23:0] copy_main_addr, main_base_address, extended_base_address, extended_field_length;
  logic [23:0] main_installed_words, ext_installed_words, redirect_addr, seq_next_addr;
  logic [23:0] mem_addr, if_addr;
  logic [59:0] operand_reg_dest, operand_reg_addr, block_copy_offset_reg, flag_reg;
  logic [59:0] mem_rdata, mem_wdata, if_rdata, ib_data, wb_data, wbd;
  int          err_count, n_compared, wr_n;
  logic [8:0]  xops [4] = '{`OP_BC_READ, `OP_BC_WRITE, `OP_EXT_READ, `OP_EXT_WRITE};
  logic [8:0]  pops [10] = '{9'h008, 9'h009, 9'h00b, 9'h010, 9'h018, 9'h038, 9'h146, 9'h17f,
                             9'h145, 9'h080};

  cp_memory_instr_and_lookahead DUT (.*);
  mem_model u_mem (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // sticky view of ill, range, req, breakin taken/ok, done, writeback
  always @(posedge clk) begin
    s <= s | {illegal_instr, addr_range_err, mem_req, breakin_taken, breakin_ok, done, wb_valid};
    wr_n <= wr_n + int'(mem_ack && mem_we);
    if (wb_valid) {wbr, wbd} <= {wb_reg, wb_data};
  end
  // ====
  // tasks
  function automatic logic [59:0] pat(input logic [23:0] a);
    return {36'h0, a} ^ 60'h0a5a_5a5a;
  endfunction
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [8:0] op);
    {s, wr_n, instr_op, instr_valid} = {7'h0, 32'h0, op, 1'b1};
    tick(1);
    instr_valid = 1'b0;
    for (int n = 0; n < 3000 && !s[1]; n++) tick(1);
    chk(s[1], 1'b1);
  endtask
  task automatic wib();
    for (int n = 0; n < 50 && !ib_valid; n++) tick(1);
  endtask
  task automatic pg(input logic [8:0] op, input logic exp);
    {s, instr_op, instr_valid} = {7'h0, op, 1'b1};
    tick(1);
    instr_valid = 1'b0;
    chk(purge, exp);
    tick(4);
    if (exp) begin
      wib();
      chk(ib_data, pat(seq_next_addr));
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ====
  // sequence
  initial begin
    {err_count, n_compared, wr_n, s} = '0;
    {instr_valid, monitor_flag, exchange_req, redirect_valid, ib_pop, slow} = '0;
    {instr_op, instr_j, index_reg, k_const, operand_reg_dest, operand_reg_addr} = '0;
    {block_copy_offset_reg, copy_main_addr, redirect_addr, seq_next_addr} = '0;
    {extended_field_length, main_base_address, extended_base_address} = {24'h0, 24'h20, 24'h10};
    {main_installed_words, ext_installed_words} = {24'h00_1000, 24'hff_ffff};
    flag_reg = 60'h100_0000_0000_0000;
    srst = 1'b1;
    tick(8);
    srst = 1'b0;
    tick(1);
    {operand_reg_addr, operand_reg_dest} = {60'h5, 60'h123_4567_89ab_cdef};
    go(`OP_EXT_WRITE);
    chk(u_mem.em[8'h15], 60'h123_4567_89ab_cdef);
    instr_j = 3'h3;
    go(`OP_EXT_READ);
    chk({wbr, wbd}, {3'h3, 60'h123_4567_89ab_cdef});
    {operand_reg_addr, operand_reg_dest} = {60'hfff_ffff_ffe0_0008, 60'hfed_cba9_8765_4321};
    go(`OP_CM_WRITE);
    chk(u_mem.mm[8'h28], 60'hfed_cba9_8765_4321);
    instr_j = 3'h5;
    go(`OP_CM_READ);
    chk({wbr, wbd}, {3'h5, 60'hfed_cba9_8765_4321});
    // two-word copies, the first against a slow memory
    {index_reg, k_const, slow, copy_main_addr} = {18'h1, 18'h1, 1'b1, 24'h40};
    block_copy_offset_reg = 60'h20_0005;
    go(`OP_BC_READ);
    chk({next_parcel2, wr_n}, {1'b1, 32'h2});
    chk(u_mem.mm[8'h60], 60'h123_4567_89ab_cdef);
    {block_copy_offset_reg, copy_main_addr, slow} = {60'h30, 24'h8, 1'b0};
    go(`OP_BC_WRITE);
    chk({next_parcel2, u_mem.em[8'h40]}, {1'b0, 60'hfed_cba9_8765_4321});
    flag_reg = '0;
    for (int i = 0; i < 4; i++) begin
      go(xops[i]);
      chk(s[6:4], 3'b100);
    end
    flag_reg = 60'h100_0000_0000_0000;
    {block_copy_offset_reg, extended_field_length} = {60'h80_0000, 24'h80_0000};
    go(`OP_BC_READ);
    chk(s[6:4], 3'b100);
    {block_copy_offset_reg, extended_field_length, index_reg, k_const} = {60'h5, 24'h0, 36'h3_ffff};
    go(`OP_BC_WRITE);
    chk(s[6:4], 3'b010);
    operand_reg_addr = 60'h2000;
    go(`OP_CM_READ);
    chk({s[4], wbd}, {1'b0, {60{1'b1}}});
    go(`OP_CM_WRITE);
    chk(s[4], 1'b0);
    // 65 words with an exchange pending: stops after the first block
    {index_reg, k_const, exchange_req, block_copy_offset_reg} = {18'h40, 18'h1, 1'b1, 60'h0};
    go(`OP_BC_READ);
    chk({s[3:2], wr_n}, {2'b11, 32'h40});
    exchange_req = 1'b0;
    pg(9'h1b1, 1'b0);
    chk(s[4], 1'b0);
    pg(9'h1b9, 1'b0);
    chk(s[4], 1'b0);
    flag_reg = '0;
    for (int m = 0; m < 2; m++) begin
      flag_reg[52] = m[0];
      for (int i = 0; i < 10; i++) begin
        seq_next_addr = 24'h200 + 24'(i);
        pg(pops[i], i < 4 || (m == 1 && i < 8));
      end
    end
    {redirect_addr, redirect_valid} = {24'h300, 1'b1};
    tick(1);
    redirect_valid = 1'b0;
    tick(3);
    wib();
    chk(ib_data, pat(24'h300));
    ib_pop = 1'b1;
    tick(1);
    ib_pop = 1'b0;
    wib();
    chk(ib_data, pat(24'h301));
    monitor_flag = 1'b1;
    tick(2);
    chk({monitor_mode, job_mode}, 2'b10);
    monitor_flag = 1'b0;
    tick(2);
    chk({monitor_mode, job_mode}, 2'b01);
    finish_test();
  end
  // watchdog: the whole sequence needs under a thousand cycles
  initial begin
    #100_000;
    err_count++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
